// file: logic/pasl_pkg.sv
// Purpose: shared constants and types for the strap and status LED pin block
// Assumes: single 20 MHz clock domain
// Notes:   strap bit positions follow the management address layout
`default_nettype none
package pasl_pkg;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned ADDR_BIT_LNK = 2;
  localparam int unsigned ADDR_BIT_RX  = 4;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam logic [4:0]  ADDR_RST     = 5'h00;

  // strap levels caught at reset release
  typedef struct packed {
    logic lnk;
    logic rx;
  } pasl_strap_t;

  // status from the transceiver core
  typedef struct packed {
    logic link_up;
    logic rx_act;
    logic speed_100;
  } pasl_status_t;

  typedef enum logic [1:0] {
    PASL_RESET,
    PASL_SAMPLE,
    PASL_RUN
  } pasl_state_t;
endpackage
`default_nettype wire

// file: logic/pasl_pin_drv.sv
// Purpose: one multiplexed strap / LED pin driver
// Assumes: polarity latched by the owner at reset release
// Notes:   drives only while enabled
`timescale 1ns/1ps
`default_nettype none
module pasl_pin_drv
  import pasl_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_int_b,
  input  wire logic ce,
  // control
  input  wire logic drive_en,
  input  wire logic strap_lvl,
  input  wire logic status_on,
  // pin
  output logic      pin_o,
  output logic      pin_oe
);
  logic pin_o_ff;
  logic pin_oe_ff;

  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      pin_oe_ff <= 1'b0;
    end else if (ce) begin
      pin_oe_ff <= drive_en;
    end
  end

  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      pin_o_ff <= 1'b0;
    end else if (ce) begin
      // asserted level is inverse of strap
      pin_o_ff <= status_on ? ~strap_lvl : strap_lvl;
    end
  end

  assign pin_o  = pin_o_ff;
  assign pin_oe = pin_oe_ff;
endmodule
`default_nettype wire

// file: logic/pasl_top.sv
// Purpose: strap sampling and status LED drive for multiplexed pins
// Assumes: pins synchronous to mclk; 25 MHz reference handled by the board
// Notes:   software reset never resamples straps
`timescale 1ns/1ps
`default_nettype none
module pasl_top
  import pasl_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = ADDR_W
)(
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  hw_reset_low_pin,
  input  wire logic                  ce,
  input  wire logic                  sw_reset,
  // core status
  input  wire pasl_status_t          status,
  // multiplexed pins
  input  wire logic                  addr2_link_led_pin_i,
  output logic                       addr2_link_led_pin_o,
  output logic                       addr2_link_led_pin_oe,
  input  wire logic                  addr4_rx_led_pin_i,
  output logic                       addr4_rx_led_pin_o,
  output logic                       addr4_rx_led_pin_oe,
  // other outputs
  output logic                       speed_indication_pin,
  output logic [ADDR_WIDTH-1:0]      mgmt_addr,
  output logic                       in_reset
);
  initial begin
    if (ADDR_WIDTH != ADDR_W) begin
      $error("pasl_top: ADDR_WIDTH must equal the strap layout width");
    end
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [SYNC_STAGES-1:0] rst_sync_ff;
  logic                   rst_int_b;

  // only the pin reset enters here; sw_reset does not
  always_ff @(posedge mclk or negedge hw_reset_low_pin) begin
    if (!hw_reset_low_pin) begin
      rst_sync_ff <= '0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_ff[SYNC_STAGES-1];

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  pasl_state_t state_ff;
  pasl_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PASL_RESET:  nxt_state = PASL_SAMPLE;
      PASL_SAMPLE: nxt_state = PASL_RUN;
      PASL_RUN:    nxt_state = PASL_RUN;
      default:     nxt_state = PASL_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      state_ff <= PASL_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  pasl_strap_t           strap_ff;
  logic [ADDR_WIDTH-1:0] addr_ff;

  // pins are still undriven in SAMPLE; caught once only
  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      strap_ff <= '0;
      addr_ff  <= ADDR_RST;
    end else if (ce && state_ff == PASL_SAMPLE) begin
      strap_ff.lnk           <= addr2_link_led_pin_i;
      strap_ff.rx            <= addr4_rx_led_pin_i;
      addr_ff[ADDR_BIT_LNK]  <= addr2_link_led_pin_i;
      addr_ff[ADDR_BIT_RX]   <= addr4_rx_led_pin_i;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  logic speed_ff;
  logic drive_en;

  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      speed_ff <= 1'b0;
    end else if (ce) begin
      speed_ff <= status.speed_100;
    end
  end

  // sw_reset intentionally not used here: pins stay outputs
  assign drive_en = (state_ff == PASL_RUN);

  pasl_pin_drv u_link_drv (
    .mclk      (mclk),
    .rst_int_b (rst_int_b),
    .ce        (ce),
    .drive_en  (drive_en),
    .strap_lvl (strap_ff.lnk),
    .status_on (status.link_up & ~sw_reset),
    .pin_o     (addr2_link_led_pin_o),
    .pin_oe    (addr2_link_led_pin_oe)
  );

  pasl_pin_drv u_rx_drv (
    .mclk      (mclk),
    .rst_int_b (rst_int_b),
    .ce        (ce),
    .drive_en  (drive_en),
    .strap_lvl (strap_ff.rx),
    .status_on (status.rx_act & ~sw_reset),
    .pin_o     (addr4_rx_led_pin_o),
    .pin_oe    (addr4_rx_led_pin_oe)
  );

  assign speed_indication_pin = speed_ff;
  assign mgmt_addr            = addr_ff;
  assign in_reset             = (state_ff != PASL_RUN);
endmodule
`default_nettype wire

// file: test/pasl_board.sv
// Purpose: board pulls with series leds on both strap pins
// Assumes: bit 0 link pin, bit 1 rx pin
// Notes:   a released pin reads its pull level
`timescale 1ns/1ps
`default_nettype none
module pasl_board (
  // pulls and device drive
  input  wire logic [1:0] pull,
  input  wire logic [1:0] drv_o,
  input  wire logic [1:0] drv_oe,
  // wire levels
  output logic      [1:0] pin,
  // reference oscillator
  output logic            ref_clk
);
  // free-running 25 MHz oscillator, 40 ns period
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  assign pin = (drv_oe & drv_o) | (~drv_oe & pull);
endmodule
`default_nettype wire

// file: test/pasl_top_props.sv
// Purpose: port checker for pasl_top
// Assumes: led and speed checks run only on enabled edges
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module pasl_top_props
  import pasl_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = ADDR_W
)(
  input wire logic                  mclk,
  input wire logic                  hw_reset_low_pin,
  input wire logic                  ce,
  input wire logic                  sw_reset,
  input wire pasl_status_t          status,
  input wire logic                  addr2_link_led_pin_i,
  input wire logic                  addr2_link_led_pin_o,
  input wire logic                  addr2_link_led_pin_oe,
  input wire logic                  addr4_rx_led_pin_i,
  input wire logic                  addr4_rx_led_pin_o,
  input wire logic                  addr4_rx_led_pin_oe,
  input wire logic                  speed_indication_pin,
  input wire logic [ADDR_WIDTH-1:0] mgmt_addr,
  input wire logic                  in_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!hw_reset_low_pin);
  hold_reset_a: assert property (disable iff (1'b0) !hw_reset_low_pin |-> in_reset)
    else $error("not in reset");
  strap_input_a: assert property (in_reset |-> !addr2_link_led_pin_oe && !addr4_rx_led_pin_oe)
    else $error("pin driven in reset");
  addr_latch_a: assert property ($fell(in_reset) |-> mgmt_addr[4:0] ==
    {$past(addr4_rx_led_pin_i), 1'b0, $past(addr2_link_led_pin_i), 2'h0}) else $error("bad addr");
  drive_after_a: assert property ($fell(in_reset) |=> addr2_link_led_pin_oe && addr4_rx_led_pin_oe)
    else $error("pins not driven");
  addr_hold_a: assert property (!in_reset && !$fell(in_reset) |-> $stable(mgmt_addr))
    else $error("addr moved");
  link_led_a: assert property (ce && !in_reset |=> addr2_link_led_pin_o ==
    ($past(status.link_up && !sw_reset) ^ mgmt_addr[2])) else $error("bad link led");
  rx_led_a: assert property (ce && !in_reset |=> addr4_rx_led_pin_o ==
    ($past(status.rx_act && !sw_reset) ^ mgmt_addr[4])) else $error("bad rx led");
  speed_out_a: assert property (ce && !in_reset |=> speed_indication_pin == $past(status.speed_100))
    else $error("bad speed");
  swrst_drive_a: assert property (sw_reset && !in_reset |=> addr2_link_led_pin_oe && addr4_rx_led_pin_oe)
    else $error("pins released");
  cover property ($fell(in_reset));
  cover property (sw_reset && !in_reset);
  cover property (status.link_up && !in_reset);
  cover property (!ce && !in_reset);
endmodule
bind pasl_top pasl_top_props #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.*);
`default_nettype wire

// file: test/tb_pasl_top.sv
// Purpose: self-checking bench for pasl_top
// Assumes: ce high except in the freeze scenario
// Notes:   straps set by board pulls
`timescale 1ns/1ps
`default_nettype none
module tb_pasl_top;
  import pasl_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic              sw = 1'b0;
  logic              ce_r = 1'b1;
  pasl_status_t      st = '0;
  logic [1:0]        pull = 2'h0;
  logic [1:0]        pin, o, oe;
  logic              spd, in_rst;
  logic [ADDR_W-1:0] addr;
  int                n_mismatch = 0;
  int                compares = 0;
  always #25 mclk = ~mclk;
  pasl_top dut_u (.mclk(mclk), .hw_reset_low_pin(rst_b), .ce(ce_r), .sw_reset(sw), .status(st),
    .addr2_link_led_pin_i(pin[0]), .addr2_link_led_pin_o(o[0]), .addr2_link_led_pin_oe(oe[0]),
    .addr4_rx_led_pin_i(pin[1]), .addr4_rx_led_pin_o(o[1]), .addr4_rx_led_pin_oe(oe[1]),
    .speed_indication_pin(spd), .mgmt_addr(addr), .in_reset(in_rst));
  pasl_board brd_u (.pull(pull), .drv_o(o), .drv_oe(oe), .pin(pin), .ref_clk());
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic strap_boot(input logic [1:0] p);
    pull = p;
    rst_b = 1'b0;
    repeat (12) @(negedge mclk);
    chk({in_rst, oe}, 5'h04);
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    chk(addr, {p[1], 1'b0, p[0], 2'h0});
    chk({in_rst, oe}, 5'h03);
  endtask
  task automatic led_run(input logic [1:0] p);
    for (int i = 0; i < 8; i++) begin
      st = i[2:0];
      @(negedge mclk);
      chk({spd, o}, {st.speed_100, st.rx_act ^ p[1], st.link_up ^ p[0]});
    end
    sw = 1'b1;
    repeat (3) @(negedge mclk);
    chk({oe, o}, {2'h3, p});
    chk(addr, {p[1], 1'b0, p[0], 2'h0});
    sw = 1'b0;
  endtask
  task automatic ce_freeze(input logic [1:0] p);
    st = '0;
    @(negedge mclk);
    ce_r = 1'b0;
    st = 3'h7;
    repeat (3) @(negedge mclk);
    chk({spd, o}, {1'b0, p});
    ce_r = 1'b1;
    @(negedge mclk);
    chk({spd, o}, {1'b1, ~p});
    st = '0;
  endtask
  initial begin
    for (int k = 0; k < 4; k++) begin
      strap_boot(k[1:0]);
      led_run(k[1:0]);
      ce_freeze(k[1:0]);
    end
    complete_run();
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
